// file: host_module_wake_handshake_test.sv
// Self-checking bench for the host and module ends joined across the wake pins.
`timescale 1ns/1ps
module host_module_wake_handshake_test;
  import wake_pkg::*;
  typedef struct packed {
    logic       hw;
    logic       mw;
    logic       rt;
    logic       ls;
    logic       d;
    logic       op;
    pwr_state_t st;
  } row_t;
  logic                   clk_sys_i = 1'h0;
  logic                   rst_n_i   = 1'h0;
  logic                   h_want = 1'h0, h_last = 1'h0, h_tx = 1'h1, h_shut = 1'h0;
  logic                   m_want = 1'h0, radio = 1'h0, m_tx = 1'h1, batt = 1'h1;
  logic                   rtc = 1'h0, tamper = 1'h0, ifw = 1'h0, ifw_en = 1'h1, h_ready = 1'h1;
  logic [RET_STEPS_W-1:0] ret_cfg = 4'h5;
  logic [SUPPLY_MV_W-1:0] supply = 13'h0708;
  logic                   h_open, h_rx, m_open, m_rx, pwr_on, rtc_on;
  logic [RET_STEPS_W-1:0] ret;
  pwr_state_t             st;
  int                     err_count = 0, checks_done = 0, cyc = 0;
  row_t                   rows [5];
  wake_if link ();
  wake_host u_wake_host (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link.host_end),
    .want_send_i(h_want), .rx_ready_i(h_ready), .tx_bit_i(h_tx), .tx_last_sent_i(h_last),
    .shutdown_req_i(h_shut), .link_open_o(h_open), .rx_bit_o(h_rx)
  );
  wake_module #(.BOOT_CYCLES(4), .PREP_CYCLES(2)) u_wake_module (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(link.module_end),
    .battery_present_i(batt), .supply_mv_i(supply), .rtc_expired_i(rtc),
    .tamper_i(tamper), .if_wake_i(ifw), .if_wake_en_i(ifw_en), .retention_steps_i(ret_cfg),
    .want_send_i(m_want), .radio_session_connected_i(radio), .tx_bit_i(m_tx),
    .state_o(st), .logic_power_on_o(pwr_on), .rtc_power_on_o(rtc_on),
    .retention_steps_o(ret), .link_open_o(m_open), .rx_bit_o(m_rx)
  );
  wake_link_sva u_wake_link_sva (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .host_wake_request(link.host_wake_request),
    .module_wake_indication(link.module_wake_indication),
    .serial_rx_from_host(link.serial_rx_from_host),
    .serial_tx_to_host(link.serial_tx_to_host), .hw_shutdown_in(link.hw_shutdown_in)
  );
  always #2 clk_sys_i = ~clk_sys_i;
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp_bit(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %b got %b", name, exp, got);
    end
  endtask
  task automatic cmp_state(pwr_state_t exp);
    checks_done++;
    if (st !== exp) begin
      err_count++;
      $display("BAD state exp %b got %b", exp, st);
    end
  endtask
  // The wait is bounded so a stuck sequencer shows as a mismatch, not a hang.
  task automatic wait_state(pwr_state_t s);
    int n;
    n = 0;
    while (st !== s && n < 80) begin
      @(negedge clk_sys_i);
      n++;
    end
    cmp_state(s);
  endtask
  task automatic repower();
    batt = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    batt = 1'h1;
    wait_state(PWR_BOOT);
    wait_state(PWR_HIBER);
  endtask
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    // The module-initiated row needs a wake event, since firmware sleeps in hibernate.
    rows = '{{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, PWR_OPEN},
             {1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, PWR_OPEN},
             {1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, PWR_HIBER},
             {1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, PWR_OPEN},
             {1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, PWR_HIBER}};
    repeat (6) @(negedge clk_sys_i);
    cmp_bit("indication", 1'h0, link.module_wake_indication);
    cmp_bit("module tx", 1'h1, link.serial_tx_to_host);
    cmp_bit("shutdown pin", 1'h1, link.hw_shutdown_in);
    cmp_state(PWR_SHUTDOWN);
    rst_n_i = 1'h1;
    wait_state(PWR_BOOT);
    wait_state(PWR_HIBER);
    foreach (rows[i]) begin
      {h_want, m_want, rtc} = {rows[i].hw, rows[i].mw, rows[i].rt};
      {h_last, h_tx} = {rows[i].ls, rows[i].d};
      m_tx = rows[i].d;
      wait_state(rows[i].st);
      repeat (6) @(negedge clk_sys_i);
      cmp_bit("host open", rows[i].op, h_open);
      cmp_bit("module open", rows[i].op, m_open);
      cmp_bit("module rx", rows[i].op ? rows[i].d : 1'h1, m_rx);
      cmp_bit("host rx", rows[i].op ? rows[i].d : 1'h1, h_rx);
    end
    cmp_bit("logic power", 1'h0, pwr_on);
    cmp_bit("rtc power", 1'h1, rtc_on);
    cmp_bit("retention", 1'h1, ret === 4'h5);
    h_want = 1'h1;
    wait_state(PWR_OPEN);
    radio = 1'h1;
    h_want = 1'h0;
    repeat (20) @(negedge clk_sys_i);
    cmp_bit("indication", 1'h0, link.module_wake_indication);
    cmp_state(PWR_ACTIVE);
    ret_cfg = 4'h9;
    radio = 1'h0;
    wait_state(PWR_HIBER);
    cmp_bit("retention", 1'h1, ret === 4'h9);
    h_ready = 1'h0;
    {m_want, rtc} = 2'h3;
    repeat (3) @(negedge clk_sys_i);
    rtc = 1'h0;
    repeat (30) @(negedge clk_sys_i);
    cmp_state(PWR_ACTIVE);
    cmp_bit("indication", 1'h1, link.module_wake_indication);
    cmp_bit("host open", 1'h0, h_open);
    h_ready = 1'h1;
    wait_state(PWR_OPEN);
    m_want = 1'h0;
    wait_state(PWR_HIBER);
    for (int k = 0; k < 3; k++) begin
      {rtc, tamper, ifw} = 3'h1 << k;
      repeat (3) @(negedge clk_sys_i);
      {rtc, tamper, ifw} = 3'h0;
      wait_state(PWR_BOOT);
      wait_state(PWR_HIBER);
    end
    ifw_en = 1'h0;
    ifw = 1'h1;
    repeat (10) @(negedge clk_sys_i);
    ifw = 1'h0;
    repeat (3) @(negedge clk_sys_i);
    cmp_state(PWR_HIBER);
    ifw_en = 1'h1;
    supply = 13'h0707;
    wait_state(PWR_SHUTDOWN);
    supply = 13'h0708;
    repower();
    h_shut = 1'h1;
    wait_state(PWR_SHUTDOWN);
    cmp_bit("shutdown pin", 1'h0, link.hw_shutdown_in);
    h_shut = 1'h0;
    repower();
    cmp_bit("shutdown pin", 1'h1, link.hw_shutdown_in);
    finish_test();
  end
endmodule

// file: wake_host.sv
// Host end of the wake handshake: opens, uses and closes the data interface.
`timescale 1ns/1ps
module wake_host (
  // Clock and reset.
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Link.
  wake_if.host_end  link,
  // User side.
  input  wire logic want_send_i,
  input  wire logic rx_ready_i,
  input  wire logic tx_bit_i,
  input  wire logic tx_last_sent_i,
  input  wire logic shutdown_req_i,
  output logic      link_open_o,
  output logic      rx_bit_o
);
  import wake_pkg::*;

  logic        ind_s1_q, ind_s2_q, tx_s1_q, tx_s2_q;
  host_state_t st_q, st_d;
  logic        req_q, req_d, rxb_q, rxb_d, sd_q, sd_d;

  always_comb begin
    st_d  = st_q;
    req_d = req_q;
    rxb_d = UART_IDLE;
    sd_d  = 1'b0;
    unique case (st_q)
      HST_IDLE: begin
        if (want_send_i) begin
          req_d = 1'b1;
          st_d  = HST_WAIT;
        end else if (ind_s2_q && rx_ready_i) begin
          req_d = 1'b1;
          st_d  = HST_WAIT;
        end else if (shutdown_req_i) begin
          sd_d = 1'b1;
        end
      end
      HST_WAIT: begin
        if (ind_s2_q) begin
          st_d = HST_OPEN;
        end
      end
      HST_OPEN: begin
        rxb_d = tx_bit_i;
        if (!want_send_i && tx_last_sent_i && tx_s2_q == UART_IDLE) begin
          st_d = HST_DRAIN;
        end
      end
      HST_DRAIN: begin
        req_d = 1'b0;
        // Reopening waits for a fresh indication, seen only after the old one has fallen.
        if (!ind_s2_q) begin
          st_d = HST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    ind_s1_q <= link.module_wake_indication;
    ind_s2_q <= ind_s1_q;
    tx_s1_q  <= link.serial_tx_to_host;
    tx_s2_q  <= tx_s1_q;
    if (!rst_n_i) begin
      st_q  <= HST_IDLE;
      req_q <= 1'b0;
      rxb_q <= UART_IDLE;
      sd_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      req_q <= req_d;
      rxb_q <= rxb_d;
      sd_q  <= sd_d;
    end
  end

  assign link.host_wake_request   = req_q;
  assign link.serial_rx_from_host = rxb_q;
  // Normally left open; driven low only on a shutdown request.
  assign link.hw_shutdown_in_o    = 1'b0;
  assign link.hw_shutdown_in_oe   = sd_q;
  assign link_open_o              = (st_q == HST_OPEN);
  assign rx_bit_o                 = tx_s2_q;
endmodule

// file: wake_if.sv
// Interface joining the host and the module across the wake handshake pins.
`timescale 1ns/1ps
interface wake_if;
  logic host_wake_request;
  logic module_wake_indication;
  logic serial_rx_from_host;
  logic serial_tx_to_host;
  logic hw_shutdown_in_o;
  logic hw_shutdown_in_oe;
  logic hw_shutdown_in;
  // Internal pull-up: line reads high unless the host drives it.
  assign hw_shutdown_in = hw_shutdown_in_oe ? hw_shutdown_in_o : 1'b1;

  modport module_end (
    input  host_wake_request,
    input  serial_rx_from_host,
    input  hw_shutdown_in,
    output module_wake_indication,
    output serial_tx_to_host
  );
  modport host_end (
    input  module_wake_indication,
    input  serial_tx_to_host,
    output host_wake_request,
    output serial_rx_from_host,
    output hw_shutdown_in_o,
    output hw_shutdown_in_oe
  );
endinterface

// file: wake_link_sva.sv
// Checker for the wake handshake pins between the host and module ends.
`timescale 1ns/1ps
module wake_link_sva (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic host_wake_request,
  input wire logic module_wake_indication,
  input wire logic serial_rx_from_host,
  input wire logic serial_tx_to_host,
  input wire logic hw_shutdown_in
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_rx_idle; !host_wake_request |-> serial_rx_from_host; endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("host line low while closed");
  property p_tx_idle; !module_wake_indication |-> serial_tx_to_host; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("module line low while closed");
  property p_early; !module_wake_indication [*4] |-> serial_rx_from_host; endproperty
  a_early: assert property (p_early) else $error("host sent before answer");
  property p_wait; host_wake_request && !module_wake_indication |=> host_wake_request; endproperty
  a_wait: assert property (p_wait) else $error("request withdrawn unanswered");
  property p_open;
    $rose(host_wake_request) && !module_wake_indication |-> ##[3:30] module_wake_indication;
  endproperty
  a_open: assert property (p_open) else $error("no answer to request");
  property p_close; $fell(host_wake_request) |-> ##[2:5] !module_wake_indication; endproperty
  a_close: assert property (p_close) else $error("indication kept after close");
  // A pin shutdown may legally drop the answer, so it is excused here.
  property p_hold;
    module_wake_indication && host_wake_request
      |=> module_wake_indication || !$past(hw_shutdown_in, 3);
  endproperty
  a_hold: assert property (p_hold) else $error("indication dropped while open");
  property p_shut;
    !hw_shutdown_in [*5] |-> !module_wake_indication && serial_tx_to_host;
  endproperty
  a_shut: assert property (p_shut) else $error("module awake in shutdown");
endmodule

// file: wake_module.sv
// Module end: power state sequencer and wake answer on the handshake pins.
`timescale 1ns/1ps
module wake_module #(
  parameter int unsigned BOOT_CYCLES = wake_pkg::BOOT_CYC,
  parameter int unsigned PREP_CYCLES = wake_pkg::PREP_CYC
)(
  // Clock and reset.
  input  wire logic                             clk_sys_i,
  input  wire logic                             rst_n_i,
  // Link.
  wake_if.module_end                            link,
  // Supply and wake sources.
  input  wire logic                             battery_present_i,
  input  wire logic [wake_pkg::SUPPLY_MV_W-1:0] supply_mv_i,
  input  wire logic                             rtc_expired_i,
  input  wire logic                             tamper_i,
  input  wire logic                             if_wake_i,
  input  wire logic                             if_wake_en_i,
  input  wire logic [wake_pkg::RET_STEPS_W-1:0] retention_steps_i,
  // Firmware side.
  input  wire logic                             want_send_i,
  input  wire logic                             radio_session_connected_i,
  input  wire logic                             tx_bit_i,
  // Status.
  output wake_pkg::pwr_state_t                  state_o,
  output logic                                  logic_power_on_o,
  output logic                                  rtc_power_on_o,
  output logic [wake_pkg::RET_STEPS_W-1:0]      retention_steps_o,
  output logic                                  link_open_o,
  output logic                                  rx_bit_o
);
  import wake_pkg::*;

  // The down-counter must hold each delay, and a delay of zero has no count state.
  if (BOOT_CYCLES < 1 || BOOT_CYCLES >= (1 << CNT_W) ||
      PREP_CYCLES < 1 || PREP_CYCLES >= (1 << CNT_W)) begin : g_bad_cycles
    $error("wake_module: cycle counts out of range");
  end

  logic       req_s1_q, req_s2_q, sd_s1_q, sd_s2_q, rx_s1_q, rx_s2_q;
  logic       bat_s1_q, bat_s2_q;
  logic       rtc_s1_q, rtc_s2_q, tmp_s1_q, tmp_s2_q, ifw_s1_q, ifw_s2_q;
  pwr_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic       ind_q, ind_d, tx_q, tx_d;
  logic [RET_STEPS_W-1:0] ret_q, ret_d;
  logic       undervoltage_lockout, wake_evt;

  // The supply code comes from a monitor on this clock, so it is not synchronised.
  // Undervoltage compare.
  assign undervoltage_lockout = (supply_mv_i < SUPPLY_MV_W'(UNDERVOLTAGE_LOCKOUT_MV));
  assign wake_evt = rtc_s2_q || req_s2_q || tmp_s2_q || (if_wake_en_i && ifw_s2_q);

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    ind_d      = ind_q;
    tx_d       = tx_q;
    ret_d      = ret_q;
    unique case (st_q)
      PWR_SHUTDOWN: begin
        ind_d = 1'b0;
        tx_d  = UART_IDLE;
        if (bat_s2_q && !undervoltage_lockout && sd_s2_q) begin
          st_d  = PWR_BOOT;
          cnt_d = CNT_W'(BOOT_CYCLES - 1);
        end
      end
      PWR_BOOT: begin
        tx_d = UART_IDLE;
        if (cnt_q == '0) begin
          st_d       = PWR_ACTIVE;
          cnt_d      = CNT_W'(PREP_CYCLES - 1);
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      PWR_ACTIVE: begin
        tx_d = UART_IDLE;
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CNT_W'(1);
        end
        if (req_s2_q && cnt_q == '0) begin
          ind_d = 1'b1;
          st_d  = PWR_OPEN;
        end else if (want_send_i && cnt_q == '0) begin
          ind_d = 1'b1;
        end else if (!req_s2_q && !ind_q && !want_send_i && cnt_q == '0 &&
                     !radio_session_connected_i) begin
          ret_d = retention_steps_i;
          st_d  = PWR_HIBER;
        end
        if (ind_q && req_s2_q) begin
          st_d = PWR_OPEN;
        end
      end
      PWR_OPEN: begin
        tx_d = tx_bit_i;
        if (!req_s2_q) begin
          ind_d = 1'b0;
          tx_d  = UART_IDLE;
          st_d  = radio_session_connected_i ? PWR_ACTIVE : PWR_HIBER;
          cnt_d = '0;
          // Retention is latched only on the way into hibernate.
          if (!radio_session_connected_i) begin
            ret_d = retention_steps_i;
          end
        end
      end
      PWR_HIBER: begin
        if (wake_evt) begin
          st_d  = PWR_BOOT;
          cnt_d = CNT_W'(BOOT_CYCLES - 1);
        end
      end
      default: begin
        st_d = PWR_SHUTDOWN;
      end
    endcase
    // Power loss overrides any transition chosen above.
    // Undervoltage power-off.
    if (!bat_s2_q || undervoltage_lockout || (!sd_s2_q && st_q != PWR_SHUTDOWN)) begin
      st_d  = PWR_SHUTDOWN;
      ind_d = 1'b0;
      tx_d  = UART_IDLE;
    end
  end

  // No reset on the synchronisers: they flush within two cycles.
  // Two-flop synchronisers.
  always_ff @(posedge clk_sys_i) begin
    req_s1_q <= link.host_wake_request;
    req_s2_q <= req_s1_q;
    sd_s1_q  <= link.hw_shutdown_in;
    sd_s2_q  <= sd_s1_q;
    rx_s1_q  <= link.serial_rx_from_host;
    rx_s2_q  <= rx_s1_q;
    bat_s1_q <= battery_present_i;
    bat_s2_q <= bat_s1_q;
    rtc_s1_q <= rtc_expired_i;
    rtc_s2_q <= rtc_s1_q;
    tmp_s1_q <= tamper_i;
    tmp_s2_q <= tmp_s1_q;
    ifw_s1_q <= if_wake_i;
    ifw_s2_q <= ifw_s1_q;
    if (!rst_n_i) begin
      st_q       <= PWR_SHUTDOWN;
      cnt_q      <= '0;
      ind_q      <= 1'b0;
      tx_q       <= UART_IDLE;
      ret_q      <= '0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      ind_q      <= ind_d;
      tx_q       <= tx_d;
      ret_q      <= ret_d;
    end
  end

  assign link.module_wake_indication = ind_q;
  assign link.serial_tx_to_host      = tx_q;
  assign state_o                     = st_q;
  // Logic off in hibernate, RTC kept.
  assign logic_power_on_o            = (st_q != PWR_SHUTDOWN) && (st_q != PWR_HIBER);
  assign rtc_power_on_o              = (st_q != PWR_SHUTDOWN);
  assign retention_steps_o           = (st_q == PWR_HIBER) ? ret_q : '0;
  assign link_open_o                 = (st_q == PWR_OPEN);
  assign rx_bit_o                    = (st_q == PWR_OPEN) ? rx_s2_q : UART_IDLE;
endmodule

// file: wake_pkg.sv
// Shared constants and types for the host/module wake handshake.
package wake_pkg;
  // Retention memory is granted in 64 KiB steps; field holds the step count.
  localparam int unsigned RET_STEP_KB   = 64;
  localparam int unsigned RET_STEPS_W   = 4;
  // Undervoltage lockout threshold, in millivolts, compared against a supply monitor code.
  localparam int unsigned UNDERVOLTAGE_LOCKOUT_MV       = 1800;
  localparam int unsigned SUPPLY_MV_W   = 13;
  // Boot and preparation delays, in cycles at the system clock.
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned BOOT_NS       = 400;
  localparam int unsigned BOOT_CYC      = (BOOT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PREP_NS       = 200;
  localparam int unsigned PREP_CYC      = (PREP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W         = 16;
  localparam logic        UART_IDLE     = 1'b1;

  typedef enum logic [2:0] {
    PWR_SHUTDOWN = 3'b000,
    PWR_BOOT     = 3'b001,
    PWR_ACTIVE   = 3'b011,
    PWR_OPEN     = 3'b010,
    PWR_HIBER    = 3'b110
  } pwr_state_t;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_WAIT = 2'b01,
    HST_OPEN = 2'b11,
    HST_DRAIN = 2'b10
  } host_state_t;
endpackage
